// [verilog/bde_consts.vh]
// register map, field positions and reset values of the dma engine
`ifndef BDE_CONSTS_VH
`define BDE_CONSTS_VH

// register byte offsets on the local port
`define BDE_OFF_CMD 16'h0000
`define BDE_OFF_LADDR 16'h0004
`define BDE_OFF_FADDR 16'h0008
`define BDE_OFF_LREM 16'h000C
`define BDE_OFF_FREM 16'h0010
`define BDE_OFF_PKT 16'h0014
`define BDE_OFF_ICTL 16'h0018
`define BDE_OFF_FCTL2 16'h001C
`define BDE_OFF_AMOD 16'h0020
`define BDE_OFF_STAT 16'h0024
// mapping registers start here, one word per index
`define BDE_OFF_MAP 16'hC000
`define BDE_MAP_SEL 2'h3

// command register fields
`define BDE_CMD_BUSY 0
`define BDE_CMD_DONE 1
`define BDE_CMD_IEN 2
`define BDE_CMD_LONG 4
`define BDE_CMD_WR 5
`define BDE_CMD_DPRAM 6
`define BDE_CMD_START 7
// option bits of the command register software may store; the command write also keeps start (bit 7)
`define BDE_CMD_WMASK 8'h7C

// interrupt control fields
`define BDE_ICTL_NIEN 6
`define BDE_ICTL_ACT 7

// far-side control two fields
`define BDE_FC2_NOIRQ 4
`define BDE_FC2_BLOCK 5
`define BDE_FC2_ZERO 6
`define BDE_FC2_PAUSE 7

// local status error bits
`define BDE_ST_BUSERR 0
`define BDE_ST_TMO 7

// page split of the local address
`define BDE_PAGE_BITS 12

// bytes per beat and bytes between rearbitrations
`define BDE_BEAT_LONG 9'h004
`define BDE_BEAT_WORD 9'h002
`define BDE_BURST_BLOCK 9'h100
`define BDE_BURST_PAUSE 9'h040

// reset values
`define BDE_RST_BYTE 8'h00
`define BDE_RST_WORD 32'h00000000
`define BDE_RST_AMOD 8'h00

// cycles a far-side handshake may hang before the engine gives up
`define BDE_TMO_CYCLES 1024

`endif

// [verilog/bde_map_mem.v]
// mapping-register memory: host page address per index, registered read
`timescale 1ns/1ps
`default_nettype none

module bde_map_mem #(
  parameter AW = 12,
  parameter DW = 32
) (
  input wire clk_i,
  input wire ce_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [DW-1:0] rdata_o
);

  // one entry per mapping index, no reset: software loads them first
  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  // write port and registered read port
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule // bde_map_mem

`default_nettype wire

// [verilog/bde_dma_engine.v]
// dma engine: register file, transfer sequencer and far-bus handshake
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bde_consts.vh"

module bde_dma_engine #(
  parameter MAP_AW = 12,
  parameter TMO_CYCLES = `BDE_TMO_CYCLES
) (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire [15:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_we_i,
  input wire reg_re_i,
  output wire [31:0] reg_rdata_o,
  input wire far_grant_i,
  input wire far_ack_i,
  input wire far_err_i,
  input wire far_irq_i,
  output reg far_bus_req_o,
  output reg far_req_o,
  output reg [31:0] far_addr_o,
  output reg [7:0] far_am_o,
  output reg far_write_o,
  output reg far_long_o,
  output reg far_dpram_o,
  output reg [31:0] host_addr_o,
  output reg irq_o,
  output reg far_irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // sequencer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ARB = 3'h1;
  localparam [2:0] ST_LOOK = 3'h2;
  localparam [2:0] ST_WAIT = 3'h3;
  localparam [2:0] ST_ISSUE = 3'h4;
  localparam [2:0] ST_ACKW = 3'h5;
  localparam [2:0] ST_REL = 3'h6;
  localparam [2:0] ST_FIN = 3'h7;

  // register offset match, used for both read and write decode
  function hit;
    input [15:0] a;
    input [15:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: grant, ack, err, far irq come from the far side
  reg [3:0] sync1_q; // first stage, read only by second
  reg [3:0] sync2_q; // usable copies
  wire grant_s = sync2_q[0];
  wire ack_s = sync2_q[1];
  wire err_s = sync2_q[2];
  wire firq_s = sync2_q[3];

  // two flops before anything looks at the pins
  always @(posedge clk_i) begin
    if (reset_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else if (ce_i) begin
      sync1_q <= {far_irq_i, far_err_i, far_ack_i, far_grant_i};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software-visible state, then sequencer and readback internals
  reg [7:0] cmd_q; // options; busy and done live apart
  reg busy_q; // transfer active
  reg done_q; // completion flag
  reg [23:0] laddr_q; // mapping index and page offset
  reg [31:0] faddr_q; // far bus address
  reg [7:0] lrem_q; // local remainder
  reg [7:0] frem_q; // far remainder, kept for readback
  reg [15:0] pkt_q; // 256-byte packet count
  reg [7:0] ictl_q; // interrupt control
  reg [7:0] fc2_q; // far-side control two
  reg [7:0] amod_q; // address modifier
  reg [7:0] stat_q; // sticky error bits
  reg [23:0] left_q; // bytes still to move
  reg [8:0] burst_q; // bytes since last arbitration
  reg [2:0] st_q; // sequencer state
  reg [15:0] tmo_q; // handshake watchdog
  reg [31:0] rdata_q; // register readback
  reg rsel_map_q; // last read hit the mapping window

  // decode of the port
  wire map_hit = (reg_addr_i[15:14] == `BDE_MAP_SEL);
  wire wr = ce_i & reg_we_i;
  wire rd = ce_i & reg_re_i;
  wire cmd_wr = wr & hit(reg_addr_i, `BDE_OFF_CMD);
  wire start = cmd_wr & reg_wdata_i[`BDE_CMD_START] & ~busy_q;

  // beat size and rearbitration span from the options
  wire [8:0] beat = cmd_q[`BDE_CMD_LONG] ? `BDE_BEAT_LONG : `BDE_BEAT_WORD;
  wire blk = fc2_q[`BDE_FC2_BLOCK];
  wire pause = blk & fc2_q[`BDE_FC2_PAUSE];
  // non-block mode lets go of the bus after every beat
  wire [8:0] span = pause ? `BDE_BURST_PAUSE : (blk ? `BDE_BURST_BLOCK : beat);
  wire [8:0] burst_nx = burst_q + beat;
  wire last = (left_q <= {15'h0000, beat});
  wire tmo_hit = (tmo_q == TMO_CYCLES[15:0] - 16'h0001);

  // map memory shares one read port: a software read takes the slot
  wire map_rd = rd & map_hit;
  wire [MAP_AW-1:0] map_idx = laddr_q[`BDE_PAGE_BITS+MAP_AW-1:`BDE_PAGE_BITS];
  wire [31:0] map_q;
  bde_map_mem #(
    .AW(MAP_AW),
    .DW(32)
  ) u_map (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(wr & map_hit),
    .waddr_i(reg_addr_i[MAP_AW+1:2]),
    .wdata_i(reg_wdata_i),
    .raddr_i(map_rd ? reg_addr_i[MAP_AW+1:2] : map_idx),
    .rdata_o(map_q)
  );

  // readback stands for exactly the cycle after the strobe
  assign reg_rdata_o = rsel_map_q ? map_q : rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // register readback
  always @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= `BDE_RST_WORD;
      rsel_map_q <= 1'b0;
    end else if (ce_i) begin
      rsel_map_q <= map_rd;
      rdata_q <= `BDE_RST_WORD;
      if (rd) begin
        // command shows live busy and done bits
        if (hit(reg_addr_i, `BDE_OFF_CMD)) begin
          rdata_q[7:0] <= {cmd_q[7:2], done_q, busy_q};
        end
        if (hit(reg_addr_i, `BDE_OFF_LADDR)) begin
          rdata_q[23:0] <= laddr_q;
        end
        if (hit(reg_addr_i, `BDE_OFF_FADDR)) begin
          rdata_q <= faddr_q;
        end
        if (hit(reg_addr_i, `BDE_OFF_LREM)) begin
          rdata_q[7:0] <= lrem_q;
        end
        if (hit(reg_addr_i, `BDE_OFF_FREM)) begin
          rdata_q[7:0] <= frem_q;
        end
        if (hit(reg_addr_i, `BDE_OFF_PKT)) begin
          rdata_q[15:0] <= pkt_q;
        end
        // active bit mirrors the live interrupt line
        if (hit(reg_addr_i, `BDE_OFF_ICTL)) begin
          rdata_q[7:0] <= {irq_o, ictl_q[6:0]};
        end
        if (hit(reg_addr_i, `BDE_OFF_FCTL2)) begin
          rdata_q[7:0] <= fc2_q;
        end
        if (hit(reg_addr_i, `BDE_OFF_AMOD)) begin
          rdata_q[7:0] <= amod_q;
        end
        if (hit(reg_addr_i, `BDE_OFF_STAT)) begin
          rdata_q[7:0] <= stat_q;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // plain setup registers
  always @(posedge clk_i) begin
    if (reset_i) begin
      lrem_q <= `BDE_RST_BYTE;
      frem_q <= `BDE_RST_BYTE;
      pkt_q <= 16'h0000;
      ictl_q <= `BDE_RST_BYTE;
      fc2_q <= `BDE_RST_BYTE;
      amod_q <= `BDE_RST_AMOD;
    end else if (wr) begin
      if (hit(reg_addr_i, `BDE_OFF_LREM)) begin
        lrem_q <= reg_wdata_i[7:0];
      end
      if (hit(reg_addr_i, `BDE_OFF_FREM)) begin
        frem_q <= reg_wdata_i[7:0];
      end
      if (hit(reg_addr_i, `BDE_OFF_PKT)) begin
        pkt_q <= reg_wdata_i[15:0];
      end
      // active bit is status only, never stored
      if (hit(reg_addr_i, `BDE_OFF_ICTL)) begin
        ictl_q <= {1'b0, reg_wdata_i[6:0]};
      end
      // bit 6 is reserved and held at zero
      if (hit(reg_addr_i, `BDE_OFF_FCTL2)) begin
        fc2_q <= reg_wdata_i[7:0] & 8'hBF;
      end
      if (hit(reg_addr_i, `BDE_OFF_AMOD)) begin
        amod_q <= reg_wdata_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command, done and status flags
  wire fin = ce_i & (st_q == ST_FIN);
  always @(posedge clk_i) begin
    if (reset_i) begin
      cmd_q <= `BDE_RST_BYTE;
      done_q <= 1'b0;
      stat_q <= `BDE_RST_BYTE;
    end else if (ce_i) begin
      // options kept; start is a one-shot and reads back as written
      if (cmd_wr) begin
        cmd_q <= {reg_wdata_i[7:2] , 2'b00} & {`BDE_CMD_WMASK | 8'h88};
      end
      // completion wins over a clear in the same cycle
      if (fin) begin
        done_q <= 1'b1;
      end else if (cmd_wr & ~reg_wdata_i[`BDE_CMD_DONE]) begin
        done_q <= 1'b0;
      end else if (start) begin
        done_q <= 1'b0;
      end
      // error bits are sticky; writing ones clears, a new error wins
      if (wr & hit(reg_addr_i, `BDE_OFF_STAT)) begin
        stat_q <= stat_q & ~reg_wdata_i[7:0];
      end
      if (start) begin
        stat_q <= `BDE_RST_BYTE;
      end
      if ((st_q == ST_ACKW || st_q == ST_ISSUE) && err_s) begin
        stat_q[`BDE_ST_BUSERR] <= 1'b1;
      end
      if ((st_q == ST_ARB || st_q == ST_ISSUE || st_q == ST_ACKW) && tmo_hit) begin
        stat_q[`BDE_ST_TMO] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  always @(posedge clk_i) begin
    if (reset_i) begin
      st_q <= ST_IDLE;
      busy_q <= 1'b0;
      laddr_q <= 24'h000000;
      faddr_q <= `BDE_RST_WORD;
      left_q <= 24'h000000;
      burst_q <= 9'h000;
      tmo_q <= 16'h0000;
      far_bus_req_o <= 1'b0;
      far_req_o <= 1'b0;
      far_addr_o <= `BDE_RST_WORD;
      far_am_o <= `BDE_RST_AMOD;
      far_write_o <= 1'b0;
      far_long_o <= 1'b0;
      far_dpram_o <= 1'b0;
      host_addr_o <= `BDE_RST_WORD;
    end else if (ce_i) begin
      // watchdog runs only while waiting on the far side
      tmo_q <= (st_q == ST_ARB || st_q == ST_ISSUE || st_q == ST_ACKW) ?
               tmo_q + 16'h0001 : 16'h0000;
      // address registers are software's while idle
      if (wr & ~busy_q & hit(reg_addr_i, `BDE_OFF_LADDR)) begin
        laddr_q <= reg_wdata_i[23:0];
      end
      if (wr & ~busy_q & hit(reg_addr_i, `BDE_OFF_FADDR)) begin
        faddr_q <= reg_wdata_i;
      end
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            busy_q <= 1'b1;
            left_q <= {pkt_q, lrem_q};
            burst_q <= 9'h000;
            st_q <= ({pkt_q, lrem_q} == 24'h000000) ? ST_FIN : ST_ARB;
          end
        end
        // ask for the far bus and hold until granted
        ST_ARB: begin
          far_bus_req_o <= 1'b1;
          if (tmo_hit) begin
            st_q <= ST_FIN;
          end else if (grant_s & far_bus_req_o) begin
            st_q <= ST_LOOK;
          end
        end
        // fetch the host page; a software map read steals the port
        ST_LOOK: begin
          if (~map_rd) begin
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          host_addr_o <= {map_q[31:`BDE_PAGE_BITS], laddr_q[`BDE_PAGE_BITS-1:0]};
          far_addr_o <= faddr_q;
          far_am_o <= amod_q;
          far_write_o <= cmd_q[`BDE_CMD_WR];
          far_long_o <= cmd_q[`BDE_CMD_LONG];
          far_dpram_o <= cmd_q[`BDE_CMD_DPRAM];
          far_req_o <= 1'b1;
          st_q <= ST_ISSUE;
        end
        // four-phase handshake: hold request until ack or error
        ST_ISSUE: begin
          if (err_s | tmo_hit) begin
            far_req_o <= 1'b0;
            st_q <= ST_FIN;
          end else if (ack_s) begin
            far_req_o <= 1'b0;
            laddr_q <= laddr_q + {15'h0000, beat};
            faddr_q <= faddr_q + {23'h000000, beat};
            left_q <= last ? 24'h000000 : left_q - {15'h0000, beat};
            burst_q <= burst_nx;
            st_q <= ST_ACKW;
          end
        end
        // wait for ack to fall before the next beat
        ST_ACKW: begin
          if (err_s | tmo_hit) begin
            st_q <= ST_FIN;
          end else if (~ack_s) begin
            if (left_q == 24'h000000) begin
              st_q <= ST_FIN;
            end else if (burst_q >= span) begin
              far_bus_req_o <= 1'b0;
              st_q <= ST_REL;
            end else begin
              st_q <= ST_LOOK;
            end
          end
        end
        // let go until the grant drops, then arbitrate again
        ST_REL: begin
          burst_q <= 9'h000;
          if (~grant_s) begin
            st_q <= ST_ARB;
          end
        end
        // busy clears in the same edge that done sets
        ST_FIN: begin
          far_bus_req_o <= 1'b0;
          far_req_o <= 1'b0;
          busy_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host interrupt and far interrupt passing
  always @(posedge clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
      far_irq_o <= 1'b0;
    end else if (ce_i) begin
      // follows done, so clearing done drops it one edge later
      irq_o <= done_q & cmd_q[`BDE_CMD_IEN] & ictl_q[`BDE_ICTL_NIEN];
      // a held far interrupt passes once blocking is lifted
      far_irq_o <= firq_s & ~fc2_q[`BDE_FC2_NOIRQ];
    end
  end

endmodule // bde_dma_engine

`default_nettype wire

// [tb/bde_dma_chk.sv]
// checker: port-level properties of the dma engine
`timescale 1ns/1ps
`default_nettype none
`include "bde_consts.vh"
module bde_dma_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic far_bus_req_o,
  input wire logic far_req_o,
  input wire logic [31:0] far_addr_o,
  input wire logic [7:0] far_am_o,
  input wire logic far_write_o,
  input wire logic far_long_o,
  input wire logic irq_o,
  input wire logic far_irq_o
);
  logic ien_q, nien_q, noirq_q; // shadows of the enable bits
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////
  // shadow what software wrote, so irq relations can be judged
  always @(posedge clk_i) begin
    if (reset_i) begin
      ien_q <= 1'b0;
      nien_q <= 1'b0;
      noirq_q <= 1'b0;
    end else if (reg_we_i) begin
      if (reg_addr_i == `BDE_OFF_CMD) ien_q <= reg_wdata_i[`BDE_CMD_IEN];
      if (reg_addr_i == `BDE_OFF_ICTL) nien_q <= reg_wdata_i[`BDE_ICTL_NIEN];
      if (reg_addr_i == `BDE_OFF_FCTL2) noirq_q <= reg_wdata_i[`BDE_FC2_NOIRQ];
    end
  end
  ////////////////////////////////////////////////////////////////
  rst_clear_a: assert property ($fell(reset_i) |-> !far_bus_req_o && !far_req_o && !irq_o)
    else $error("outputs not clear after reset");
  req_hold_a: assert property ($rose(far_req_o) |=> far_req_o [*2])
    else $error("beat request dropped early");
  req_owner_a: assert property (far_req_o |-> far_bus_req_o)
    else $error("beat request without bus ownership");
  beat_stable_a: assert property (far_req_o && $past(far_req_o) |->
    $stable({far_addr_o, far_am_o, far_write_o, far_long_o})) else $error("beat changed");
  busy_read_a: assert property (reg_re_i && reg_addr_i == `BDE_OFF_CMD &&
    far_req_o |=> reg_rdata_o[1:0] == 2'b01) else $error("busy or done wrong during a beat");
  irq_enable_a: assert property ($rose(irq_o) |-> ien_q && nien_q)
    else $error("interrupt without both enables");
  irq_drop_a: assert property (reg_we_i && reg_addr_i == `BDE_OFF_CMD &&
    !reg_wdata_i[`BDE_CMD_DONE] && !reg_wdata_i[`BDE_CMD_START] |=> ##1 !irq_o)
    else $error("interrupt stays after done cleared");
  irq_block_a: assert property (noirq_q && $past(noirq_q) |-> !far_irq_o)
    else $error("far interrupt passed while blocked");
  cover property ($rose(irq_o));
  cover property ($fell(far_bus_req_o));
  cover property (far_req_o && far_long_o && far_write_o);
endmodule // bde_dma_chk
bind bde_dma_engine bde_dma_chk u_chk (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .far_bus_req_o, .far_req_o, .far_addr_o,
  .far_am_o, .far_write_o, .far_long_o, .irq_o, .far_irq_o);
`default_nettype wire

// [tb/bde_far_model.sv]
// far-bus slave model: grant, four-phase ack or error, beat log
`timescale 1ns/1ps
`default_nettype none
module bde_far_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic bus_req_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] host_i,
  input wire logic err_i,
  input wire logic slow_i,
  input wire logic clr_i,
  output logic grant_o,
  output logic ack_o,
  output logic err_o,
  output logic [15:0] beats_o,
  output logic [15:0] grants_o,
  output logic [31:0] first_far_o,
  output logic [31:0] last_host_o
);
  logic [7:0] wt_q; // cycles waited on the open request
  wire [7:0] lat = slow_i ? 8'h06 : 8'h01; // slow stays below the engine timeout
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (reset_i || clr_i) begin
      {grant_o, ack_o, err_o, wt_q} <= '0;
      {beats_o, grants_o, first_far_o, last_host_o} <= '0;
    end else begin
      wt_q <= ((bus_req_i && !grant_o) || (req_i && !ack_o && !err_o)) ? wt_q + 8'h01 : 8'h00;
      // grant drops with the request so each rearbitration is seen
      if (!bus_req_i) grant_o <= 1'b0;
      else if (!grant_o && wt_q >= lat) begin
        grant_o <= 1'b1;
        grants_o <= grants_o + 16'h0001;
      end
      // answer held until the engine lets go of the request
      if (!req_i) {ack_o, err_o} <= 2'b00;
      else if (!ack_o && !err_o && wt_q >= lat) begin
        if (err_i) err_o <= 1'b1;
        else ack_o <= 1'b1;
        if (beats_o == 16'h0000) first_far_o <= addr_i;
        last_host_o <= host_i;
        beats_o <= beats_o + 16'h0001;
      end
    end
  end
endmodule // bde_far_model
`default_nettype wire

// [tb/test_bus_adapter_dma_engine.sv]
// testbench of the dma engine against the far-bus model
`timescale 1ns/1ps
`default_nettype none
`include "bde_consts.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module test_bus_adapter_dma_engine;
  localparam logic [7:0] NB_AM = 8'h0D; // non-block modifier, plain default
  logic clk_i = 0, reset_i = 1, reg_we_i = 0, reg_re_i = 0, far_irq_i = 0, ce_i = 1;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [31:0] reg_wdata_i = 32'h00000000;
  logic err_q = 0, slow_q = 0, clr_q = 0; // model controls
  wire [31:0] reg_rdata_o, far_addr_o, host_addr_o, first_far, last_host;
  wire far_grant_i, far_ack_i, far_err_i, far_bus_req_o, far_req_o;
  wire far_write_o, far_long_o, far_dpram_o, irq_o, far_irq_o;
  wire [7:0] far_am_o;
  wire [15:0] beats, grants;
  int bad_count = 0, total_checks = 0, cyc = 0;
  logic [31:0] map_m [0:3]; // mirror of the mapping words
  bde_dma_engine #(.TMO_CYCLES(16)) u_dut (.clk_i, .reset_i, .ce_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .far_grant_i, .far_ack_i,
    .far_err_i, .far_irq_i, .far_bus_req_o, .far_req_o, .far_addr_o, .far_am_o,
    .far_write_o, .far_long_o, .far_dpram_o, .host_addr_o, .irq_o, .far_irq_o);
  bde_far_model u_far (.clk_i, .reset_i, .bus_req_i(far_bus_req_o), .req_i(far_req_o),
    .addr_i(far_addr_o), .host_i(host_addr_o), .err_i(err_q), .slow_i(slow_q),
    .clr_i(clr_q), .grant_o(far_grant_i), .ack_o(far_ack_i), .err_o(far_err_i),
    .beats_o(beats), .grants_o(grants), .first_far_o(first_far), .last_host_o(last_host));
  always #2.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, well above the longest expected run
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  function automatic int ceil_div(int a, int b);
    return (a + b - 1) / b;
  endfunction
  ////////////////////////////////////////////////////////////////
  // one full transfer; mode 0 non-block, 1 block, 2 pause
  task automatic xfer(input int mode, input int len, input logic err);
    logic [7:0] opt, am, fc;
    logic [31:0] la, fa, d, le;
    logic nien;
    int bs, nb, n, sp;
    opt = 8'($urandom) & 8'h74; // start, bit3, done, busy clear
    nien = 1'($urandom);
    la = {8'h00, 11'h000, 1'($urandom), 12'($urandom) & 12'hFFC};
    fa = $urandom & 32'hFFFFFFFC;
    am = mode == 0 ? NB_AM : 8'h0F; // modifier fits mode and address size
    fc = mode == 0 ? 8'h10 : (mode == 1 ? 8'h30 : 8'hB0); // far irq blocked
    bs = opt[`BDE_CMD_LONG] ? 4 : 2;
    nb = ceil_div(len, bs);
    err_q <= err;
    slow_q <= 1'($urandom);
    clr_q <= 1'b1;
    wr(`BDE_OFF_CMD, {24'h000000, opt}); // options first
    clr_q <= 1'b0;
    wr(`BDE_OFF_LADDR, la);
    wr(`BDE_OFF_FADDR, fa);
    wr(`BDE_OFF_LREM, len % 256); // same remainder twice
    wr(`BDE_OFF_FREM, len % 256);
    wr(`BDE_OFF_PKT, len / 256); // whole packets
    wr(`BDE_OFF_ICTL, {25'h0000000, nien, 6'h00});
    wr(`BDE_OFF_FCTL2, {24'h000000, fc});
    wr(`BDE_OFF_AMOD, {24'h000000, am});
    rd(`BDE_OFF_CMD, d);
    wr(`BDE_OFF_CMD, d | 32'h00000080); // read back, add start
    rd(`BDE_OFF_CMD, d);
    `CHK("busy", 1'b1, d[0])
    n = 0;
    while (far_req_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("far_write", opt[5], far_write_o)
    `CHK("far_long", opt[4], far_long_o)
    `CHK("far_dpram", opt[6], far_dpram_o)
    `CHK("far_am", am, far_am_o)
    n = 0;
    // sparse polling, only the command register while busy
    do begin
      repeat (20) @(posedge clk_i);
      rd(`BDE_OFF_CMD, d);
      n++;
    end while (d[1] !== 1'b1 && n < 600);
    `CHK("cmd_end", 2'b10, d[1:0])
    `CHK("irq", opt[2] & nien, irq_o)
    rd(`BDE_OFF_STAT, d);
    `CHK("status", {7'h00, err}, d[7:0])
    if (!err) begin
      le = la + (nb - 1) * bs;
      `CHK("beats", 16'(nb), beats)
      `CHK("far_start", fa, first_far)
      `CHK("host_last", {map_m[le[13:12]][31:12], le[11:0]}, last_host)
      sp = mode == 0 ? bs : (mode == 1 ? 256 : 64);
      `CHK("grants", 16'(ceil_div(nb * bs, sp)), grants)
    end
    wr(`BDE_OFF_STAT, 32'h000000FF);
    wr(`BDE_OFF_CMD, 32'h00000000); // clear after status
    repeat (2) @(posedge clk_i);
    #1 `CHK("irq_drop", 1'b0, irq_o)
    wr(`BDE_OFF_FCTL2, 32'h00000000); // restore passing
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    void'($urandom(49));
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`BDE_OFF_CMD, d);
    `CHK("cmd_reset", 32'h00000000, d)
    rd(16'h0040, d);
    `CHK("unmapped", 32'h00000000, d)
    for (int i = 0; i < 4; i++) begin
      map_m[i] = $urandom & 32'hFFFFF000;
      wr(`BDE_OFF_MAP + 16'(4 * i), map_m[i]);
    end
    rd(`BDE_OFF_MAP + 16'h0004, d);
    `CHK("map_read", map_m[1], d)
    // transfer 1 is exactly one packet, transfer 4 fails on the far bus
    for (int i = 0; i < 9; i++)
      xfer(i % 3, i == 1 ? 256 : 2 + $urandom % 510, i == 4);
    far_irq_i <= 1'b1;
    wr(`BDE_OFF_FCTL2, 32'h00000010);
    repeat (6) @(posedge clk_i);
    #1 `CHK("irq_blocked", 1'b0, far_irq_o)
    // silent far side: the watchdog ends the transfer with done and timeout
    clr_q <= 1'b1;
    wr(`BDE_OFF_CMD, 32'h00000080);
    repeat (40) @(posedge clk_i);
    rd(`BDE_OFF_CMD, d);
    `CHK("cmd_tmo", 32'h00000082, d)
    rd(`BDE_OFF_STAT, d);
    `CHK("status_tmo", 32'h00000080, d)
    // frozen clock enable: a start written now must leave no trace
    ce_i <= 1'b0;
    wr(`BDE_OFF_CMD, 32'h00000080);
    ce_i <= 1'b1;
    clr_q <= 1'b0;
    rd(`BDE_OFF_CMD, d);
    `CHK("cmd_frozen", 32'h00000082, d)
    wr(`BDE_OFF_FCTL2, 32'h00000000);
    repeat (4) @(posedge clk_i);
    #1 `CHK("irq_passed", 1'b1, far_irq_o)
    complete_run();
  end
endmodule // test_bus_adapter_dma_engine
`default_nettype wire
